/* rtl/scp_pkg.sv */
/*
 * constants, field layouts and carrier types of the surround control port.
 * assumes one 8-bit word per command and a 3-bit command selector.
 */
package scp_pkg;
  // serial command frame: selector then data, msb first
  localparam int SEL_W = 3;
  localparam int DATA_W = 8;
  localparam int FRAME_W = SEL_W + DATA_W;
  // command selectors
  localparam logic [2:0] SEL_SUM_ATT = 3'h0;
  localparam logic [2:0] SEL_DIFF_ATT = 3'h1;
  localparam logic [2:0] SEL_DELAY = 3'h2;
  localparam logic [2:0] SEL_GAIN = 3'h3;
  localparam logic [2:0] SEL_REVERB = 3'h4;
  localparam logic [2:0] SEL_MODE = 3'h5;
  // reset values of the six command words
  localparam logic [7:0] RST_SUM_ATT = 8'h50;
  localparam logic [7:0] RST_DIFF_ATT = 8'h50;
  localparam logic [7:0] RST_DELAY = 8'hA5;
  localparam logic [7:0] RST_GAIN = 8'h6C;
  localparam logic [7:0] RST_REVERB = 8'h44;
  localparam logic [7:0] RST_MODE = 8'h60;
  // field positions in the mode word
  localparam int MODE_MUTE = 7;
  localparam int MODE_PWR = 6;
  localparam int MODE_BYP = 5;
  localparam int MODE_TEST_HI = 3;
  // forbidden delay scale code
  localparam logic [3:0] DS_FORBID = 4'hF;
  // audio word and frame shape
  localparam int AUD_W = 16;
  localparam int OUT_BITS = 48;
  localparam int OUT_HALF_BITS = OUT_BITS / 2;
  localparam int OUT_PAD = OUT_HALF_BITS - AUD_W;
  // initialization length in input samples
  localparam logic [7:0] INIT_SAMPLES = 8'h80;

  // decoded parameter set
  typedef struct packed {
    logic [7:0] sum_input_attenuation;
    logic [7:0] diff_input_attenuation;
    logic [4:0] delay_scale;
    logic [3:0] raw_gain;
    logic [3:0] sum_gain;
    logic [3:0] diff_gain;
    logic [3:0] sum_reverb_gain;
    logic [3:0] diff_reverb_gain;
    logic [3:0] test_setting;
  } scp_params_t;

  // serial audio pin triple
  typedef struct packed {
    logic word_clock;
    logic bit_clock;
    logic data;
  } scp_audio_t;
endpackage : scp_pkg

/* rtl/scp_surround_control_port.sv */
/*
 * control side of a stereo surround processor: serial command
 * port, six parameter words, mute, power-down, bypass and
 * initialization sequencing, audio input capture and 48fs output.
 * assumes ref_clk far faster than any audio or host clock, and a
 * host bit clock that stands still outside command frames.
 */
// Notes on behaviour
// - three-wire serial port, six write commands
// - attenuators scale code/256, zero silences, default 0x50
// - delay scale bits 7-4, code+1, 0xF forbidden
// - raw gain low nibble, code times 0.0625
// - sum/diff gains in 0.125 steps
// - reverb gains in 0.125 steps
// - mode bits: mute, power low, bypass low
// - mute changes at output word rising edge
// - mute start runs 128-sample memory clear
// - power-down by pin low or flag zero
// - power-down stops logic, outputs held low
// - leaving power-down runs initialization
// - bypass routes inputs straight to outputs
// - bypass stops all other circuits; the command port, synchronisers and mode decode keep running
// - leaving bypass runs initialization
// - reset release runs initialization
// - input 16-bit msb-first right-justified
// - output 16-bit right-justified at 48fs
// - outputs low in power-down or reset
module scp_surround_control_port
  import scp_pkg::*;
#(
  parameter int OUT_HALF = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic host_bit_clock,
  input wire logic host_serial_data_pin,
  input wire logic host_latch_strobe_b,
  input wire logic power_down_low,
  input wire logic bypass_select_low,
  input wire scp_audio_t audio_in,
  output scp_audio_t audio_out,
  output scp_params_t params,
  output logic direct_mute_flag,
  output logic mute_active,
  output logic init_active,
  output logic power_down_active,
  output logic bypass_active,
  output logic ds_forbidden
);

  ////////////////////////////////////////////////////////////////
  // host bit clock domain

  // shift register, no reset: only the latch gives it meaning
  logic [FRAME_W-1:0] host_shift;

  // msb first, sampled on host clock rising edge
  always_ff @(posedge host_bit_clock) begin
    host_shift <= {host_shift[FRAME_W-2:0], host_serial_data_pin};
  end

  ////////////////////////////////////////////////////////////////
  // pin synchronisers into ref_clk

  // stage one, read only by stage two
  logic [6:0] sync_a;
  // stage two, the usable levels
  logic [6:0] sync_b;
  // raw pin gather
  logic [6:0] pins_raw;
  assign pins_raw = {host_latch_strobe_b, power_down_low,
                     bypass_select_low, audio_in.word_clock,
                     audio_in.bit_clock, audio_in.data, 1'b0};

  // two flops per pin
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sync_a <= 7'h7E;
      sync_b <= 7'h7E;
    end else begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end

  // named synced levels
  logic strobe_b_s;
  logic pwr_pin_s;
  logic byp_pin_s;
  logic iwck_s;
  logic ibck_s;
  logic idat_s;
  assign strobe_b_s = sync_b[6];
  assign pwr_pin_s = sync_b[5];
  assign byp_pin_s = sync_b[4];
  assign iwck_s = sync_b[3];
  assign ibck_s = sync_b[2];
  assign idat_s = sync_b[1];

  // previous synced levels for edge detection
  logic strobe_b_d;
  logic iwck_d;
  logic ibck_d;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      strobe_b_d <= 1'b1;
      iwck_d <= 1'b1;
      ibck_d <= 1'b1;
    end else begin
      strobe_b_d <= strobe_b_s;
      iwck_d <= iwck_s;
      ibck_d <= ibck_s;
    end
  end

  // latch at the end of the low strobe pulse
  logic latch_evt;
  assign latch_evt = strobe_b_s && !strobe_b_d;
  // input clock events
  logic ibck_rise;
  logic iwck_edge;
  logic iwck_rise;
  assign ibck_rise = ibck_s && !ibck_d;
  assign iwck_edge = iwck_s ^ iwck_d;
  assign iwck_rise = iwck_s && !iwck_d;

  ////////////////////////////////////////////////////////////////
  // command words

  // the six stored words
  logic [7:0] w_sum_att;
  logic [7:0] w_diff_att;
  logic [7:0] w_delay;
  logic [7:0] w_gain;
  logic [7:0] w_reverb;
  logic [7:0] w_mode;
  // decoded frame fields
  logic [SEL_W-1:0] frame_sel;
  logic [DATA_W-1:0] frame_data;
  // host clock is parked when the strobe rises, so the word is
  // quasi-static and safe to take as a bus
  assign frame_sel = host_shift[FRAME_W-1:DATA_W];
  assign frame_data = host_shift[DATA_W-1:0];

  // apply latched word to selected register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      w_sum_att <= RST_SUM_ATT;
      w_diff_att <= RST_DIFF_ATT;
      w_delay <= RST_DELAY;
      w_gain <= RST_GAIN;
      w_reverb <= RST_REVERB;
      w_mode <= RST_MODE;
    end else if (latch_evt) begin
      // unknown selectors fall through and are ignored
      unique case (frame_sel)
        SEL_SUM_ATT: begin
          w_sum_att <= frame_data;
        end
        SEL_DIFF_ATT: begin
          w_diff_att <= frame_data;
        end
        SEL_DELAY: begin
          w_delay <= frame_data;
        end
        SEL_GAIN: begin
          w_gain <= frame_data;
        end
        SEL_REVERB: begin
          w_reverb <= frame_data;
        end
        SEL_MODE: begin
          w_mode <= frame_data;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // parameter decode

  // fields to the datapath; attenuation is code/256 there
  always_comb begin
    params.sum_input_attenuation = w_sum_att;
    params.diff_input_attenuation = w_diff_att;
    // multiplier is code plus one
    params.delay_scale = {1'b0, w_delay[7:4]} + 5'h01;
    params.raw_gain = w_delay[3:0];
    params.sum_gain = w_gain[7:4];
    params.diff_gain = w_gain[3:0];
    params.sum_reverb_gain = w_reverb[7:4];
    params.diff_reverb_gain = w_reverb[3:0];
    params.test_setting = w_mode[MODE_TEST_HI:0];
  end

  // flag forbidden scale code for software visibility
  assign ds_forbidden = (w_delay[7:4] == DS_FORBID);
  assign direct_mute_flag = w_mode[MODE_MUTE];

  ////////////////////////////////////////////////////////////////
  // mode decode

  // power-down from pin or flag
  logic next_pd;
  assign next_pd = !pwr_pin_s || !w_mode[MODE_PWR];
  // bypass from pin or flag, power-down wins
  logic next_byp;
  assign next_byp = (!byp_pin_s || !w_mode[MODE_BYP]) && !next_pd;

  // registered mode states
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      power_down_active <= 1'b0;
      bypass_active <= 1'b0;
    end else begin
      power_down_active <= next_pd;
      bypass_active <= next_byp;
    end
  end

  // processing runs only when neither mode holds it
  logic run;
  assign run = !power_down_active && !bypass_active;

  ////////////////////////////////////////////////////////////////
  // initialization sequencer

  // samples still to clear
  logic [7:0] init_cnt;
  // mute flag history for its rising edge
  logic mute_flag_d;

  // held full while stopped, so exit restarts the clear;
  // reset loads it too, so release starts the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      init_cnt <= INIT_SAMPLES;
      mute_flag_d <= 1'b0;
    end else begin
      mute_flag_d <= w_mode[MODE_MUTE];
      if (!run) begin
        init_cnt <= INIT_SAMPLES;
      end else if (w_mode[MODE_MUTE] && !mute_flag_d) begin
        init_cnt <= INIT_SAMPLES;
      end else if (iwck_rise && init_cnt != 8'h00) begin
        // one step per input sample period
        init_cnt <= init_cnt - 8'h01;
      end
    end
  end

  assign init_active = run && (init_cnt != 8'h00);

  ////////////////////////////////////////////////////////////////
  // audio input capture

  // bit shifter, last 16 bits form the word
  logic [AUD_W-1:0] in_shift;
  // captured left and right words
  logic [AUD_W-1:0] left_word;
  logic [AUD_W-1:0] right_word;

  // right-justified: word ends at the word clock edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      in_shift <= 16'h0000;
      left_word <= 16'h0000;
      right_word <= 16'h0000;
    end else if (run) begin
      if (ibck_rise) begin
        in_shift <= {in_shift[AUD_W-2:0], idat_s};
      end
      if (iwck_edge) begin
        // high half carries the left word
        if (iwck_d) begin
          left_word <= in_shift;
        end else begin
          right_word <= in_shift;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // output frame generator

  // ref cycles within one output bit clock half
  logic [15:0] half_cnt;
  // output bit clock level
  logic obck;
  // bit slot within the 48-bit frame
  logic [5:0] bit_cnt;
  // mute state, changes only at frame start
  logic mute_q;
  // word being sent
  logic [AUD_W-1:0] out_word;

  // falling edge of output bit clock is the data step
  logic obck_fall;
  assign obck_fall = obck && (half_cnt == 16'(OUT_HALF - 1));
  // slot position within a half frame
  logic [5:0] slot;
  assign slot = (bit_cnt >= 6'(OUT_HALF_BITS)) ?
                bit_cnt - 6'(OUT_HALF_BITS) : bit_cnt;

  // bit clock divider, fixed 48 bits per frame
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !run) begin
      half_cnt <= 16'h0000;
      obck <= 1'b0;
      bit_cnt <= 6'h00;
    end else if (half_cnt == 16'(OUT_HALF - 1)) begin
      half_cnt <= 16'h0000;
      obck <= !obck;
      if (obck) begin
        // wrap gives the word clock rising boundary
        bit_cnt <= (bit_cnt == 6'(OUT_BITS - 1)) ?
                   6'h00 : bit_cnt + 6'h01;
      end
    end else begin
      half_cnt <= half_cnt + 16'h0001;
    end
  end

  // mute taken at the word clock rising boundary only, so a
  // word is never cut halfway
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mute_q <= 1'b0;
    end else if (obck_fall && bit_cnt == 6'(OUT_BITS - 1)) begin
      mute_q <= w_mode[MODE_MUTE];
    end
  end

  // muted also while memory is being cleared
  assign mute_active = mute_q || init_active;

  // mute level for the word being loaded; at a frame start it is
  // the flag that mute_q takes on the same edge, so the first word
  // after the word clock rise is already silent
  logic frame_mute;
  assign frame_mute = (bit_cnt == 6'(OUT_BITS - 1)) ?
                      w_mode[MODE_MUTE] : mute_q;

  // word loaded at each half start
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      out_word <= 16'h0000;
    end else if (obck_fall && slot == 6'(OUT_HALF_BITS - 1)) begin
      if (frame_mute || init_active) begin
        out_word <= 16'h0000;
      end else if (bit_cnt == 6'(OUT_BITS - 1)) begin
        out_word <= left_word;
      end else begin
        out_word <= right_word;
      end
    end
  end

  // data bit for the slot being entered; leading pad is zero
  logic [5:0] nslot;
  logic nbit;
  logic [3:0] nidx;
  always_comb begin
    nslot = (slot == 6'(OUT_HALF_BITS - 1)) ? 6'h00 : slot + 6'h01;
    nidx = 4'(6'(OUT_HALF_BITS - 1) - nslot);
    nbit = (nslot >= 6'(OUT_PAD)) ? out_word[nidx] : 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // output pins

  // data from flops; bypass copies synced inputs, power-down and
  // reset pull everything low
  always_ff @(posedge ref_clk) begin
    if (!rst_b || next_pd) begin
      audio_out <= 3'b000;
    end else if (next_byp) begin
      audio_out.word_clock <= iwck_s;
      audio_out.bit_clock <= ibck_s;
      audio_out.data <= idat_s;
    end else begin
      // low on the restart cycle, so the first half is full length
      audio_out.word_clock <= run && (bit_cnt < 6'(OUT_HALF_BITS));
      audio_out.bit_clock <= obck;
      // stale bypass data or a word cut by the clear never leaks out
      if (!run || init_active) begin
        audio_out.data <= 1'b0;
      end else if (obck_fall) begin
        audio_out.data <= nbit;
      end
    end
  end

endmodule : scp_surround_control_port

/* testbench/scp_host_model.sv */
/*
 * host controller model on the three-wire command port.
 * assumes the device only needs a short quiet gap after each latch.
 */
module scp_host_model (
  output logic host_bit_clock,
  output logic host_serial_data_pin,
  output logic host_latch_strobe_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels: clock stands still outside frames
  initial begin
    host_bit_clock = 1'b0;
    host_serial_data_pin = 1'b0;
    host_latch_strobe_b = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  // one frame: selector then data, msb first, 80 ns bit clock
  task automatic send_cmd(input logic [2:0] sel, input logic [7:0] data);
    logic [10:0] frame;
    frame = {sel, data};
    #3.7;  // keeps phase unrelated to the system clock
    host_latch_strobe_b = 1'b0;
    for (int i = 10; i >= 0; i--) begin
      host_serial_data_pin = frame[i];
      #20 host_bit_clock = 1'b1;
      #40 host_bit_clock = 1'b0;
      #20;
    end
    // released line shows the opposite of the last bit, never stale
    host_serial_data_pin = ~frame[0];
    host_latch_strobe_b = 1'b1;
    #40;  // clock quiet well past four system cycles
  endtask : send_cmd
endmodule : scp_host_model

/* testbench/scp_monitor.sv */
/*
 * checker for the surround control port, bound to its top module.
 * assumes output bit clock half period of OUT_HALF system cycles.
 */
module scp_monitor
  import scp_pkg::*;
#(
  parameter int OUT_HALF = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic host_latch_strobe_b,
  input wire scp_audio_t audio_in,
  input wire scp_audio_t audio_out,
  input wire scp_params_t params,
  input wire logic direct_mute_flag,
  input wire logic mute_active,
  input wire logic init_active,
  input wire logic power_down_active,
  input wire logic bypass_active
);
  localparam int HALF_CYC = OUT_BITS * OUT_HALF;  // cycles per half
  default clocking mon_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [1:0] wc_d;  // word clock history
  logic [2:0] busy_d;  // init, power-down or bypass history
  logic [3:0] since_ld;  // cycles since latch rise, saturating
  logic ld_q;
  int half_cnt;  // cycles in current word clock half
  logic half_seen;  // a full edge seen since normal running
  logic busy, stop, stop_d, wc_edge, wc_rose;
  assign busy = init_active | power_down_active | bypass_active;
  assign stop = power_down_active | bypass_active;
  assign wc_edge = audio_out.word_clock != wc_d[0];
  // word clock rose over the last edge
  assign wc_rose = audio_out.word_clock & ~wc_d[0];
  //////////////////////////////////////////////////////////////////////
  // histories; reset to busy so stale values never qualify
  always_ff @(posedge ref_clk) begin
    wc_d <= {wc_d[0], audio_out.word_clock};
    busy_d <= !rst_b ? 3'b111 : {busy_d[1:0], busy};
    stop_d <= stop;
  end
  // latch age
  always_ff @(posedge ref_clk) begin
    ld_q <= !rst_b | host_latch_strobe_b;
    if (!rst_b) since_ld <= 4'hF;
    else if (host_latch_strobe_b && !ld_q) since_ld <= 4'h0;
    else if (since_ld != 4'hF) since_ld <= since_ld + 4'h1;
  end
  // half length, restarted whenever the generator was stopped
  always_ff @(posedge ref_clk) begin
    if (!rst_b || stop || stop_d) begin
      half_cnt <= 0;
      half_seen <= 1'b0;
    end else if (wc_edge) begin
      half_cnt <= 1;
      half_seen <= 1'b1;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  rst_out_a: assert property (disable iff (1'b0) !rst_b |=>
    audio_out == '0 && params.sum_input_attenuation == 8'h50)
    else $error("outputs or words not at rest after reset");
  pd_out_a: assert property (power_down_active |-> audio_out == '0)
    else $error("outputs driven in power-down");
  pd_init_a: assert property ($fell(power_down_active) |-> ##[0:2] init_active)
    else $error("no init after power-down");
  byp_init_a: assert property ($fell(bypass_active) && !power_down_active
    |-> ##[0:2] init_active) else $error("no init after bypass");
  mute_init_a: assert property ($rose(direct_mute_flag) |-> ##[0:2] init_active)
    else $error("no init on mute");
  frame_mute_a: assert property ($changed(mute_active) && !busy &&
    busy_d == 3'b000 |-> ##1 wc_rose) else $error("mute off frame boundary");
  mute_data_a: assert property (mute_active && $past(mute_active) &&
    !bypass_active && !power_down_active |-> !audio_out.data)
    else $error("data while muted");
  byp_copy_a: assert property (bypass_active && $past(bypass_active, 4)
    |-> audio_out == $past(audio_in, 3)) else $error("bypass not copied");
  half_len_a: assert property (half_seen && wc_edge && !stop |->
    half_cnt == HALF_CYC) else $error("output half frame length wrong");
  latch_only_a: assert property ($changed(params) |-> since_ld <= 4'd7)
    else $error("words changed without latch");
  cover property ($fell(mute_active) && busy_d == 3'b000);
  cover property ($fell(bypass_active));
  cover property ($fell(init_active));
endmodule : scp_monitor

bind scp_surround_control_port scp_monitor #(.OUT_HALF(OUT_HALF)) scp_monitor_i (
  .ref_clk, .rst_b, .host_latch_strobe_b, .audio_in, .audio_out, .params,
  .direct_mute_flag, .mute_active, .init_active, .power_down_active,
  .bypass_active);

/* testbench/tb_surround_control_port.sv */
/*
 * bench for the surround control port: defaults, writes, mute with
 * init, power-down, bypass, second reset.
 * assumes the host model and checker are compiled before it.
 */
module tb_surround_control_port;
  import scp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic power_down_low = 1'b1;
  logic bypass_select_low = 1'b1;
  logic [7:0] ain_cnt = 8'h00;  // audio input pattern counter
  logic host_bit_clock, host_serial_data_pin, host_latch_strobe_b;
  scp_audio_t audio_in, audio_out;
  scp_params_t params;
  logic direct_mute_flag, mute_active, init_active;
  logic power_down_active, bypass_active, ds_forbidden;
  int mismatches = 0;
  int tests_run = 0;
  // input audio: 16 bit clocks per word, word clock period 128 cycles
  assign audio_in = {ain_cnt[6], ain_cnt[1], ain_cnt[3]};
  initial forever #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) ain_cnt <= ain_cnt + 8'h01;
  scp_host_model scp_host_model_i (.host_bit_clock, .host_serial_data_pin,
    .host_latch_strobe_b);
  scp_surround_control_port #(.OUT_HALF(2)) scp_surround_control_port_i (
    .ref_clk, .rst_b, .host_bit_clock, .host_serial_data_pin,
    .host_latch_strobe_b, .power_down_low, .bypass_select_low, .audio_in,
    .audio_out, .params, .direct_mute_flag, .mute_active, .init_active,
    .power_down_active, .bypass_active, .ds_forbidden);
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cycles
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    scp_host_model_i.send_cmd(sel, d);
    cycles(8);  // word lands a few cycles after latch
  endtask : wr
  task automatic finish_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////
  // defaults of all six words
  task automatic t_defaults();
    scp_params_t e;
    e = '{8'h50, 8'h50, 5'd11, 4'h5, 4'h6, 4'hC, 4'h4, 4'h4, 4'h0};
    check(params, e);
    check({direct_mute_flag, power_down_active, bypass_active}, 3'b000);
  endtask : t_defaults
  // every selector, boundary codes, forbidden scale, unused selector
  task automatic t_writes();
    scp_params_t p;
    wr(SEL_SUM_ATT, 8'h00);
    wr(SEL_DIFF_ATT, 8'hFF);
    check({params.sum_input_attenuation, params.diff_input_attenuation}, 16'h00FF);
    wr(SEL_DELAY, 8'hF0);
    check(ds_forbidden, 1'b1);
    wr(SEL_DELAY, 8'h0F);
    check({ds_forbidden, params.delay_scale, params.raw_gain}, {1'b0, 5'd1, 4'hF});
    wr(SEL_DELAY, 8'hE3);
    check({params.delay_scale, params.raw_gain}, {5'd15, 4'h3});
    wr(SEL_GAIN, 8'hF1);
    check({params.sum_gain, params.diff_gain}, 8'hF1);
    wr(SEL_REVERB, 8'h1F);
    check({params.sum_reverb_gain, params.diff_reverb_gain}, 8'h1F);
    p = params;
    wr(3'h6, 8'hAA);
    check(params, p);
    wr(SEL_MODE, 8'h6F);
    check(params.test_setting, 4'hF);
    wr(SEL_MODE, 8'h60);
    check(params.test_setting, 4'h0);
  endtask : t_writes
  // mute starts a 128-sample init, release waits for a frame
  task automatic t_mute();
    int n;
    n = 0;
    wr(SEL_MODE, 8'hE0);
    check({direct_mute_flag, init_active, mute_active}, 3'b111);
    while (init_active === 1'b1 && n < 200) begin
      @(negedge ref_clk);
      if (ain_cnt[6:0] == 7'h40) n++;
    end
    check(n >= 126 && n <= 130, 1'b1);
    check(mute_active, 1'b1);
    wr(SEL_MODE, 8'h60);
    n = 0;
    while (mute_active === 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    check(mute_active, 1'b0);
  endtask : t_mute
  // power-down by pin and by flag, muted around it
  task automatic t_pdown();
    wr(SEL_MODE, 8'hE0);
    power_down_low = 1'b0;
    cycles(6);
    check({power_down_active, audio_out}, 4'b1000);
    power_down_low = 1'b1;
    cycles(6);
    check({power_down_active, init_active}, 2'b01);
    wr(SEL_MODE, 8'hA0);
    check({power_down_active, audio_out}, 4'b1000);
    wr(SEL_MODE, 8'hE0);
    check({power_down_active, init_active}, 2'b01);
  endtask : t_pdown
  // bypass by pin and by flag, muted around it
  task automatic t_bypass();
    bypass_select_low = 1'b0;
    cycles(6);
    check(bypass_active, 1'b1);
    bypass_select_low = 1'b1;
    cycles(6);
    check({bypass_active, init_active}, 2'b01);
    wr(SEL_MODE, 8'hC0);
    check(bypass_active, 1'b1);
    wr(SEL_MODE, 8'hE0);
    check({bypass_active, init_active}, 2'b01);
    wr(SEL_MODE, 8'h60);
  endtask : t_bypass
  // mid-run reset restores defaults and restarts init
  task automatic t_reset();
    rst_b = 1'b0;
    cycles(10);
    check(audio_out, 3'b000);
    rst_b = 1'b1;
    cycles(2);
    check(init_active, 1'b1);
    t_defaults();
  endtask : t_reset
  //////////////////////////////////////////////////////////////////////
  initial begin
    cycles(10);
    rst_b = 1'b1;
    cycles(2);
    check(init_active, 1'b1);
    t_defaults();
    t_writes();
    t_mute();
    t_pdown();
    t_bypass();
    t_reset();
    finish_test();
  end
  // watchdog, about three times the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
endmodule : tb_surround_control_port
